// ===== inc/motor_reg_link_if.sv
/*
  Register link between the host end and the register-bank end.
  Assumes both ends run on the same mclk.
*/
`timescale 1ns/10ps
`default_nettype none
interface motor_reg_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev_end (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host_end (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// ===== inc/motor_regs_pkg.sv
/*
  Constants shared by the register-bank end and the host end of the
  motor telemetry and parameter register link.
  Assumes one 20 MHz core clock shared by both ends.
*/
// Function
// - Host reads speed high byte before low
// - Speed is 16-bit, tenth-hertz units, concatenated
// - Host reads period high byte before low
// - Period is 16-bit, 10 microsecond steps
// - Velocity constant is twice digital constant
// - Peak current 11-bit, top three in byte
// - Current converts with knee at 1023
// - Read-only inductive rotor position with advance
// - Supply level scaled value times 30/256
// - Speed command byte, all ones full
// - Buffered speed command bits 8 to 1
// - Fault causes one bit per cause
// - Param one top bit picks 25/50 kHz
// - Resistance is mantissa shifted by count
// - Param two top bit picks adjustment mode
// - Back-EMF constant is mantissa shifted by count
// - Reload bit copies nonvolatile image into params
// - Config writes need write-enable bit set
package motor_regs_pkg;

  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] ADDR_CTRL = 8'h03;
  localparam logic [7:0] ADDR_SPEED_HIGH = 8'h11;
  localparam logic [7:0] ADDR_SPEED_LOW = 8'h12;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h13;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h14;
  localparam logic [7:0] ADDR_VCONST_HIGH = 8'h15;
  localparam logic [7:0] ADDR_VCONST_LOW = 8'h16;
  localparam logic [7:0] ADDR_CURRENT_HIGH = 8'h17;
  localparam logic [7:0] ADDR_CURRENT_LOW = 8'h18;
  localparam logic [7:0] ADDR_ROTOR_POS = 8'h19;
  localparam logic [7:0] ADDR_SUPPLY = 8'h1A;
  localparam logic [7:0] ADDR_SPEED_CMD = 8'h1B;
  localparam logic [7:0] ADDR_BUF_SPEED_CMD = 8'h1C;
  localparam logic [7:0] ADDR_FAULT = 8'h1E;
  localparam logic [7:0] ADDR_PARAM_ONE = 8'h20;
  localparam logic [7:0] ADDR_PARAM_TWO = 8'h21;

  // ****************
  // Fields and resets
  // ****************
  localparam int CTRL_CFG_WE_BIT = 6;
  localparam int CTRL_RELOAD_BIT = 5;
  localparam int PARAM_SELECT_BIT = 7;
  localparam logic [7:0] PARAM_ONE_RESET = 8'h4A;
  localparam logic [7:0] PARAM_TWO_RESET = 8'h4E;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [10:0] CURRENT_KNEE = 11'h3FF;

  // ****************
  // Timing
  // ****************
  localparam int CLOCK_KHZ = 20000;
  localparam int PWM_SLOW_KHZ = 25;
  localparam int PWM_FAST_KHZ = 50;
  localparam logic [9:0] PWM_SLOW_CYCLES = 10'(CLOCK_KHZ / PWM_SLOW_KHZ);
  localparam logic [9:0] PWM_FAST_CYCLES = 10'(CLOCK_KHZ / PWM_FAST_KHZ);

  // Host command kinds
  typedef enum logic [1:0] {
    CMD_READ_BYTE,
    CMD_WRITE_BYTE,
    CMD_READ_WORD,
    CMD_WRITE_CONFIG
  } cmd_kind_e;

  // Mantissa in [3:0] shifted left by count in [6:4]
  function automatic logic [10:0] shifted_code(input logic [6:0] code);
    shifted_code = 11'({7'h00, code[3:0]} << code[6:4]);
  endfunction

endpackage

// ===== rtl/motor_regs_host.sv
/*
  Host end: turns user commands into register link transactions,
  reading word values high byte first and opening the config write
  enable before a parameter write.
  Assumes the far end answers every request with ack one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module motor_regs_host (
  input wire logic mclk,
  input wire logic rst_n,
  motor_reg_link_if.host_end link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [1:0] kind;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic req;
    logic we;
    logic [7:0] link_addr;
    logic [7:0] link_wdata;
    logic ready;
    logic rsp;
    logic [15:0] data;
  } host_s;

  host_s q;
  host_s d;

  // ****************
  // Next state
  // ****************
  always_comb begin
    d = q;
    d.req = 1'b0;
    d.rsp = 1'b0;
    unique case (q.state)
      ST_IDLE: begin
        if (cmd_valid && q.ready) begin
          d.kind = cmd_kind;
          d.addr = cmd_addr;
          d.wdata = cmd_wdata;
          d.ready = 1'b0;
          d.state = ST_FIRST;
          d.req = 1'b1;
          d.we = (cmd_kind == motor_regs_pkg::CMD_WRITE_BYTE) ||
                 (cmd_kind == motor_regs_pkg::CMD_WRITE_CONFIG);
          d.link_addr = cmd_addr;
          d.link_wdata = cmd_wdata;
          if (cmd_kind == motor_regs_pkg::CMD_WRITE_CONFIG) begin
            d.link_addr = motor_regs_pkg::ADDR_CTRL;
            d.link_wdata = 8'h00;
            d.link_wdata[motor_regs_pkg::CTRL_CFG_WE_BIT] = 1'b1;
          end
        end
      end
      ST_FIRST: begin
        if (link.ack) begin
          // Word reads: high byte at addr, then low byte at addr+1
          if (q.kind == motor_regs_pkg::CMD_READ_WORD) begin
            d.data = {link.rdata, 8'h00};
            d.req = 1'b1;
            d.we = 1'b0;
            d.link_addr = 8'(q.addr + 8'h01);
            d.state = ST_SECOND;
          end else if (q.kind == motor_regs_pkg::CMD_WRITE_CONFIG) begin
            d.req = 1'b1;
            d.we = 1'b1;
            d.link_addr = q.addr;
            d.link_wdata = q.wdata;
            d.state = ST_SECOND;
          end else begin
            d.data = {8'h00, link.rdata};
            d.rsp = 1'b1;
            d.ready = 1'b1;
            d.state = ST_IDLE;
          end
        end
      end
      ST_SECOND: begin
        if (link.ack) begin
          if (q.kind == motor_regs_pkg::CMD_READ_WORD) begin
            d.data = {q.data[15:8], link.rdata};
          end
          d.rsp = 1'b1;
          d.ready = 1'b1;
          d.state = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
        d.ready = 1'b1;
      end
    endcase
  end

  // ****************
  // Registers
  // ****************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.req = q.req;
  assign link.we = q.we;
  assign link.addr = q.link_addr;
  assign link.wdata = q.link_wdata;
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rsp;
  assign rsp_data = q.data;

endmodule // motor_regs_host
`default_nettype wire

// ===== rtl/motor_telemetry_param_regs.sv
/*
  Register-bank end: telemetry read-back, fault causes and the two
  motor parameter registers, served over the register link.
  Assumes telemetry inputs are synchronous to mclk and that the
  host reads high bytes before low bytes.
*/
`timescale 1ns/10ps
`default_nettype none
module motor_telemetry_param_regs (
  input wire logic mclk,
  input wire logic rst_n,
  motor_reg_link_if.dev_end link,
  input wire logic [15:0] rotor_velocity,
  input wire logic [15:0] electrical_period,
  input wire logic [15:0] measured_velocity_constant,
  input wire logic [10:0] peak_phase_current,
  input wire logic [7:0] rotor_position_estimate,
  input wire logic [7:0] supply_level,
  input wire logic [7:0] speed_command_value,
  input wire logic [8:0] buffered_speed_command,
  input wire logic stuck_closed_loop_flag,
  input wire logic stuck_open_loop_flag,
  input wire logic no_motor_flag,
  input wire logic constant_abnormal_flag,
  input wire logic speed_abnormal_flag,
  input wire logic lock_current_limit_flag,
  input wire logic [7:0] nvm_param_one,
  input wire logic [7:0] nvm_param_two,
  output logic pwm_rate_select,
  output logic [9:0] pwm_period_cycles,
  output logic [10:0] phase_resistance_code,
  output logic loop_adjust_select,
  output logic [10:0] bemf_constant_code,
  output logic [10:0] current_steps_above_knee,
  output logic current_above_knee,
  output logic config_write_enable
);

  // ****************
  // State
  // ****************
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [3:0][7:0] low_shadow;
    logic cfg_we;
    logic nvm_reload;
    logic [7:0] param_one;
    logic [7:0] param_two;
    logic [9:0] pwm_cycles;
    logic [10:0] res_code;
    logic [10:0] bemf_code;
    logic [10:0] cur_steps;
    logic cur_knee;
  } bank_s;

  bank_s q;
  bank_s d;

  // Shadow slot for each multi-byte value
  localparam int SLOT_SPEED = 0;
  localparam int SLOT_PERIOD = 1;
  localparam int SLOT_VCONST = 2;
  localparam int SLOT_CURRENT = 3;

  logic [7:0] fault_byte;
  assign fault_byte = {2'b00, stuck_closed_loop_flag, stuck_open_loop_flag, no_motor_flag,
                       constant_abnormal_flag, speed_abnormal_flag, lock_current_limit_flag};

  // ****************
  // Next state
  // ****************
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.nvm_reload = 1'b0;

    // Reload pulse lands one cycle after the control write
    if (q.nvm_reload) begin
      d.param_one = nvm_param_one;
      d.param_two = nvm_param_two;
    end

    if (link.req) begin
      d.ack = 1'b1;
      if (link.we) begin
        unique case (link.addr)
          motor_regs_pkg::ADDR_CTRL: begin
            d.cfg_we = link.wdata[motor_regs_pkg::CTRL_CFG_WE_BIT];
            d.nvm_reload = link.wdata[motor_regs_pkg::CTRL_RELOAD_BIT];
          end
          motor_regs_pkg::ADDR_PARAM_ONE: begin
            if (q.cfg_we) begin
              d.param_one = link.wdata;
            end
          end
          motor_regs_pkg::ADDR_PARAM_TWO: begin
            if (q.cfg_we) begin
              d.param_two = link.wdata;
            end
          end
          default: begin
            // Read-only and unmapped writes are dropped
          end
        endcase
      end else begin
        unique case (link.addr)
          motor_regs_pkg::ADDR_CTRL: begin
            d.rdata = 8'h00;
            d.rdata[motor_regs_pkg::CTRL_CFG_WE_BIT] = q.cfg_we;
          end
          motor_regs_pkg::ADDR_SPEED_HIGH: begin
            d.rdata = rotor_velocity[15:8];
            d.low_shadow[SLOT_SPEED] = rotor_velocity[7:0];
          end
          motor_regs_pkg::ADDR_SPEED_LOW: begin
            d.rdata = q.low_shadow[SLOT_SPEED];
          end
          motor_regs_pkg::ADDR_PERIOD_HIGH: begin
            d.rdata = electrical_period[15:8];
            d.low_shadow[SLOT_PERIOD] = electrical_period[7:0];
          end
          motor_regs_pkg::ADDR_PERIOD_LOW: begin
            d.rdata = q.low_shadow[SLOT_PERIOD];
          end
          motor_regs_pkg::ADDR_VCONST_HIGH: begin
            d.rdata = measured_velocity_constant[15:8];
            d.low_shadow[SLOT_VCONST] = measured_velocity_constant[7:0];
          end
          motor_regs_pkg::ADDR_VCONST_LOW: begin
            d.rdata = q.low_shadow[SLOT_VCONST];
          end
          motor_regs_pkg::ADDR_CURRENT_HIGH: begin
            d.rdata = {5'b00000, peak_phase_current[10:8]};
            d.low_shadow[SLOT_CURRENT] = peak_phase_current[7:0];
          end
          motor_regs_pkg::ADDR_CURRENT_LOW: begin
            d.rdata = q.low_shadow[SLOT_CURRENT];
          end
          motor_regs_pkg::ADDR_ROTOR_POS: begin
            d.rdata = rotor_position_estimate;
          end
          motor_regs_pkg::ADDR_SUPPLY: begin
            d.rdata = supply_level;
          end
          motor_regs_pkg::ADDR_SPEED_CMD: begin
            d.rdata = speed_command_value;
          end
          motor_regs_pkg::ADDR_BUF_SPEED_CMD: begin
            d.rdata = buffered_speed_command[8:1];
          end
          motor_regs_pkg::ADDR_FAULT: begin
            d.rdata = fault_byte;
          end
          motor_regs_pkg::ADDR_PARAM_ONE: begin
            d.rdata = q.param_one;
          end
          motor_regs_pkg::ADDR_PARAM_TWO: begin
            d.rdata = q.param_two;
          end
          default: begin
            d.rdata = motor_regs_pkg::UNMAPPED_READ;
          end
        endcase
      end
    end

    // Derived outputs follow the parameter registers one edge later
    d.pwm_cycles = q.param_one[motor_regs_pkg::PARAM_SELECT_BIT] ?
                   motor_regs_pkg::PWM_FAST_CYCLES : motor_regs_pkg::PWM_SLOW_CYCLES;
    d.res_code = motor_regs_pkg::shifted_code(q.param_one[6:0]);
    d.bemf_code = motor_regs_pkg::shifted_code(q.param_two[6:0]);

    // Numerator of amps times 512/3, with the offset above the knee
    d.cur_knee = (peak_phase_current >= motor_regs_pkg::CURRENT_KNEE);
    d.cur_steps = d.cur_knee ? 11'(peak_phase_current - motor_regs_pkg::CURRENT_KNEE)
                             : peak_phase_current;
  end

  // ****************
  // Registers
  // ****************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.param_one <= motor_regs_pkg::PARAM_ONE_RESET;
      q.param_two <= motor_regs_pkg::PARAM_TWO_RESET;
      q.pwm_cycles <= motor_regs_pkg::PWM_SLOW_CYCLES;
    end else begin
      q <= d;
    end
  end

  assign link.ack = q.ack;
  assign link.rdata = q.rdata;
  assign pwm_rate_select = q.param_one[motor_regs_pkg::PARAM_SELECT_BIT];
  assign pwm_period_cycles = q.pwm_cycles;
  assign phase_resistance_code = q.res_code;
  assign loop_adjust_select = q.param_two[motor_regs_pkg::PARAM_SELECT_BIT];
  assign bemf_constant_code = q.bemf_code;
  assign current_steps_above_knee = q.cur_steps;
  assign current_above_knee = q.cur_knee;
  assign config_write_enable = q.cfg_we;

endmodule // motor_telemetry_param_regs
`default_nettype wire

// ===== verif/motor_telemetry_param_regs_assertions.sv
/*
  Checker for the register link between host end and register bank.
  Assumes one mclk domain and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module motor_telemetry_param_regs_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  // ****************
  // Link checks
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_ack_next_cycle: assert property (req |=> ack)
    else $error("ack missing one cycle after request");
  chk_ack_has_cause: assert property (ack |-> $past(req))
    else $error("ack without a request");
  chk_req_single_pulse: assert property (req |=> !req)
    else $error("request held longer than one cycle");
  chk_speed_high_first: assert property (req && !we && addr == 8'h11 ##2 req |-> !we && addr == 8'h12)
    else $error("speed word not read high then low");
  chk_low_after_high:
    assert property (req && !we && (addr == 8'h14 || addr == 8'h16 || addr == 8'h18)
    && $past(req, 2) |-> $past(addr, 2) == addr - 8'h01)
    else $error("low byte read without its high byte");
  chk_current_top_zero: assert property (req && !we && addr == 8'h17 ##1 ack |-> rdata[7:3] == 5'h00)
    else $error("current high byte unused bits set");
  chk_fault_top_zero: assert property (req && !we && addr == 8'h1E ##1 ack |-> rdata[7:6] == 2'h0)
    else $error("fault byte unused bits set");
  chk_cfg_enable_first:
    assert property (req && we && addr[7:1] == 7'h10 && $past(req, 2)
    |-> $past(we, 2) && $past(addr, 2) == 8'h03 && ($past(wdata, 2) & 8'h40) == 8'h40)
    else $error("parameter write not preceded by enable");
  chk_rdata_holds: assert property (!(ack && $past(req) && !$past(we)) |-> $stable(rdata))
    else $error("read data changed without a read");

  cov_speed_word: cover property (req && addr == 8'h11 ##2 req && addr == 8'h12);
  cov_config_write: cover property (req && we && addr == 8'h03 ##2 req && we && addr == 8'h20);
  cov_fault_seen: cover property (req && !we && addr == 8'h1E ##1 ack && rdata != 8'h00);
endmodule // motor_telemetry_param_regs_assertions
`default_nettype wire

// ===== verif/motor_telemetry_param_regs_tb_top.sv
/*
  Testbench: host end and register bank joined by the link interface.
  Assumes the design answers on the contract latencies, no parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module motor_telemetry_param_regs_tb_top;
  logic mclk, rst_n, cmd_valid, cmd_ready, rsp_valid, pwm_sel, adj_sel, above, cfg_en;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_addr, cmd_wdata, pos, sup, scmd, nvm1, nvm2;
  logic [15:0] vel, per, vc, rsp_data;
  logic [10:0] cur, res_code, bemf_code, steps;
  logic [8:0] bscmd;
  logic [5:0] flt;
  logic [9:0] pwm_per;
  int n_fail, comparisons, cycles;

  motor_reg_link_if motor_reg_link_if_inst();
  motor_telemetry_param_regs motor_telemetry_param_regs_inst (.mclk(mclk), .rst_n(rst_n),
    .link(motor_reg_link_if_inst), .rotor_velocity(vel), .electrical_period(per),
    .measured_velocity_constant(vc), .peak_phase_current(cur), .rotor_position_estimate(pos),
    .supply_level(sup), .speed_command_value(scmd), .buffered_speed_command(bscmd),
    .stuck_closed_loop_flag(flt[5]), .stuck_open_loop_flag(flt[4]), .no_motor_flag(flt[3]),
    .constant_abnormal_flag(flt[2]), .speed_abnormal_flag(flt[1]), .lock_current_limit_flag(flt[0]),
    .nvm_param_one(nvm1), .nvm_param_two(nvm2), .pwm_rate_select(pwm_sel), .pwm_period_cycles(pwm_per),
    .phase_resistance_code(res_code), .loop_adjust_select(adj_sel), .bemf_constant_code(bemf_code),
    .current_steps_above_knee(steps), .current_above_knee(above), .config_write_enable(cfg_en));
  motor_regs_host motor_regs_host_inst (.mclk(mclk), .rst_n(rst_n), .link(motor_reg_link_if_inst),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  motor_telemetry_param_regs_assertions motor_telemetry_param_regs_assertions_inst (.mclk(mclk),
    .rst_n(rst_n), .req(motor_reg_link_if_inst.req), .we(motor_reg_link_if_inst.we),
    .addr(motor_reg_link_if_inst.addr), .wdata(motor_reg_link_if_inst.wdata),
    .ack(motor_reg_link_if_inst.ack), .rdata(motor_reg_link_if_inst.rdata));

  // ****************
  // Shared tasks
  // ****************
  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Waits are bounded so a silent host cannot hang the run
  task automatic cmd(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (n == 1) begin
        chk("busy", 16'h0000, 16'(cmd_ready));
      end
    end while (rsp_valid !== 1'b1 && n < 8);
    // Counted from the taking edge: two edges per link transfer
    chk("latency", k[1] ? 16'h0004 : 16'h0002, 16'(n));
    chk("ready", 16'h0001, 16'(cmd_ready));
  endtask

  task automatic rd(input string nm, input logic [1:0] k, input logic [7:0] a, input logic [15:0] e);
    cmd(k, a, 8'h00);
    chk(nm, e, rsp_data);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    @(posedge mclk);
    #1;
    chk("pwm_period", 16'(motor_regs_pkg::PWM_SLOW_CYCLES), 16'(pwm_per));
    chk("resistance", 16'h00A0, 16'(res_code));
    chk("bemf", 16'h00E0, 16'(bemf_code));
    chk("cfg_enable", 16'h0000, 16'(cfg_en));
    rd("param_one", 2'h0, 8'h20, 16'h004A);
    rd("param_two", 2'h0, 8'h21, 16'h004E);
  endtask

  task automatic t_words();
    @(posedge mclk);
    vel <= 16'h01FF;
    per <= 16'h1234;
    vc <= 16'hA55A;
    cur <= 11'h43C;
    rd("speed", 2'h2, 8'h11, 16'h01FF);
    rd("period", 2'h2, 8'h13, 16'h1234);
    rd("vconst", 2'h2, 8'h15, 16'hA55A);
    rd("current", 2'h2, 8'h17, 16'h043C);
    chk("steps", 16'h003D, 16'(steps));
    chk("above", 16'h0001, 16'(above));
    @(posedge mclk);
    cur <= 11'h3FE;
    @(posedge mclk);
    #1;
    chk("steps", 16'h03FE, 16'(steps));
    chk("above", 16'h0000, 16'(above));
  endtask

  // Low byte must come from the sample taken at the high read
  task automatic t_latch();
    rd("speed_high", 2'h0, 8'h11, 16'h0001);
    @(posedge mclk);
    vel <= 16'hABCD;
    rd("speed_low", 2'h0, 8'h12, 16'h00FF);
    rd("speed_new", 2'h2, 8'h11, 16'hABCD);
  endtask

  task automatic t_bytes();
    @(posedge mclk);
    pos <= 8'h5A;
    sup <= 8'h67;
    scmd <= 8'hFF;
    bscmd <= 9'h1FC;
    rd("rotor_pos", 2'h0, 8'h19, 16'h005A);
    rd("supply", 2'h0, 8'h1A, 16'h0067);
    rd("speed_cmd", 2'h0, 8'h1B, 16'h00FF);
    rd("buf_cmd", 2'h0, 8'h1C, 16'h00FE);
    rd("unmapped", 2'h0, 8'h1D, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      flt <= 6'(1 << i);
      rd("fault", 2'h0, 8'h1E, 16'(1 << i));
    end
  endtask

  task automatic t_param();
    cmd(2'h1, 8'h20, 8'hC3);
    chk("rate_locked", 16'h0000, 16'(pwm_sel));
    cmd(2'h3, 8'h20, 8'hC3);
    cmd(2'h3, 8'h21, 8'hA5);
    cmd(2'h1, 8'h19, 8'h00);
    chk("rate_sel", 16'h0001, 16'(pwm_sel));
    chk("pwm_period", 16'(motor_regs_pkg::PWM_FAST_CYCLES), 16'(pwm_per));
    chk("resistance", 16'h0030, 16'(res_code));
    chk("adjust", 16'h0001, 16'(adj_sel));
    chk("bemf", 16'h0014, 16'(bemf_code));
    chk("cfg_enable", 16'h0001, 16'(cfg_en));
    rd("rotor_ro", 2'h0, 8'h19, 16'h005A);
    rd("param_one", 2'h0, 8'h20, 16'h00C3);
  endtask

  task automatic t_reload();
    @(posedge mclk);
    nvm1 <= 8'h12;
    nvm2 <= 8'h37;
    cmd(2'h1, 8'h03, 8'h60);
    @(posedge mclk);
    #1;
    chk("rate_sel", 16'h0000, 16'(pwm_sel));
    chk("pwm_period", 16'(motor_regs_pkg::PWM_SLOW_CYCLES), 16'(pwm_per));
    chk("resistance", 16'h0004, 16'(res_code));
    chk("adjust", 16'h0000, 16'(adj_sel));
    chk("bemf", 16'h0038, 16'(bemf_code));
    rd("param_two", 2'h0, 8'h21, 16'h0037);
    rd("ctrl", 2'h0, 8'h03, 16'h0040);
  endtask

  // ****************
  // Clock, timeout, main
  // ****************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    {vel, per, vc, cur, pos, sup, scmd, bscmd, flt, nvm1, nvm2} = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_words();
    t_latch();
    t_bytes();
    t_param();
    t_reload();
    end_sim();
  end
endmodule // motor_telemetry_param_regs_tb_top
`default_nettype wire
